/* hw/cssu_pkg.sv */
package cssu_pkg;
  // ==========================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL18 = 8'h04;
  localparam logic [7:0] ADDR_CTRL19 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // ==========================================
  // field positions
  localparam int BIT_IN_PTR_EN = 5;
  localparam int BIT_OUT_PTR_EN = 4;
  localparam int BIT_DIV_EN = 1;
  localparam int BIT_SRC_SEL = 1;
  localparam int IRQ_W = 5;
  localparam int EV_IN_PTR = 0;
  localparam int EV_OUT_PTR = 1;
  localparam int EV_DIV = 2;
  localparam int EV_FAULT = 3;
  localparam int EV_EARLY_TX = 4;
  localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL18_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL19_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 25;
  localparam int RESET_MIN_CYC_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_CYC = (RESET_MIN_CYC_RAW < 1) ? 1 : RESET_MIN_CYC_RAW;
  // ==========================================
  // sequence states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_SYNCED = 4'b0100,
    ST_TX = 4'b1000
  } cssu_state_type;
  // ==========================================
  // bus carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } cssu_axi_req_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cssu_axi_rsp_type;
endpackage

/* hw/cssu_sync_startup.sv */
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ns
// What this block does
// - control word zero bit 5 lets frame pulses reset the input pointer
// - control word zero bit 4 lets the output pointer be synchronised
// - control word nineteen bit 1 picks output pointer and divider source
// - control word eighteen bit 1 set lets sync pulses reach the divider
// - single source mode passes the input pointer reset on to the output pointer three cycles later
module cssu_sync_startup (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire cssu_pkg::cssu_axi_req_type axi_req,
  output cssu_pkg::cssu_axi_rsp_type axi_rsp,
  // pins from the host
  input wire logic transmit_gate_pin,
  input wire logic active_low_reset_pin,
  input wire logic frame_sync_pair,
  input wire logic output_strobe_sync_pair,
  input wire logic clock_lost_flag,
  input wire logic collision_alarm_flag,
  // to the datapath
  output logic in_ptr_reset,
  output logic out_ptr_reset,
  output logic divider_sync,
  output logic transmit_active,
  output logic irq
);
  import cssu_pkg::*;

  // ==========================================
  // pin synchronisers
  logic [1:0] gate_s, rpin_s, frm_s, str_s, lost_s, alm_s;
  logic frm_q, str_q;
  always_ff @(posedge clk) begin
    gate_s <= {gate_s[0], transmit_gate_pin};
    rpin_s <= {rpin_s[0], active_low_reset_pin};
    frm_s <= {frm_s[0], frame_sync_pair};
    str_s <= {str_s[0], output_strobe_sync_pair};
    lost_s <= {lost_s[0], clock_lost_flag};
    alm_s <= {alm_s[0], collision_alarm_flag};
    frm_q <= frm_s[1];
    str_q <= str_s[1];
  end
  logic frame_rise, strobe_rise, fault;
  assign frame_rise = frm_s[1] & ~frm_q;
  assign strobe_rise = str_s[1] & ~str_q;
  assign fault = lost_s[1] | alm_s[1];

  // ==========================================
  // device reset from the pin, low time qualified
  logic [3:0] rlow_reg, rlow_next;
  logic dev_rst;
  always_comb begin
    rlow_next = rpin_s[1] ? 4'h0 : ((rlow_reg == 4'hF) ? rlow_reg : rlow_reg + 4'h1);
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rlow_reg <= 4'h0;
    end else begin
      rlow_reg <= rlow_next;
    end
  end
  assign dev_rst = !rstn || (rlow_reg >= 4'(RESET_MIN_CYC));

  // ==========================================
  // register file and bus slave
  logic [31:0] ctrl0_reg, ctrl0_next, ctrl18_reg, ctrl18_next, ctrl19_reg, ctrl19_next;
  logic [IRQ_W-1:0] stat_reg, stat_next, mask_reg, mask_next, events;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next, bvalid_reg, bvalid_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  cssu_state_type state_reg, state_next;
  logic en_in, en_out, en_div, sel_dual;
  assign en_in = ctrl0_reg[BIT_IN_PTR_EN];
  assign en_out = ctrl0_reg[BIT_OUT_PTR_EN];
  assign en_div = ctrl18_reg[BIT_DIV_EN];
  assign sel_dual = ctrl19_reg[BIT_SRC_SEL];

  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    ctrl0_next = ctrl0_reg;
    ctrl18_next = ctrl18_reg;
    ctrl19_next = ctrl19_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (axi_req.awvalid && axi_rsp.awready) begin
      aw_got_next = 1'b1;
      awaddr_next = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      w_got_next = 1'b1;
      wdata_next = axi_req.wdata;
    end
    if (bvalid_reg && axi_req.bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_got_reg && w_got_reg) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (awaddr_reg)
        ADDR_CTRL0: ctrl0_next = wdata_reg;
        ADDR_CTRL18: ctrl18_next = wdata_reg;
        ADDR_CTRL19: ctrl19_next = wdata_reg;
        ADDR_IRQ_MASK: mask_next = wdata_reg[IRQ_W-1:0];
        ADDR_IRQ_STAT: stat_next = stat_reg & ~wdata_reg[IRQ_W-1:0];
        ADDR_STATUS: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    // set wins over a clear in the same cycle
    stat_next = stat_next | events;
    if (rvalid_reg && axi_req.rready) begin
      rvalid_next = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (axi_req.araddr)
        ADDR_CTRL0: rdata_next = ctrl0_reg;
        ADDR_CTRL18: rdata_next = ctrl18_reg;
        ADDR_CTRL19: rdata_next = ctrl19_reg;
        ADDR_STATUS: rdata_next = {27'h000_0000, transmit_active, state_reg};
        ADDR_IRQ_STAT: rdata_next = {27'h000_0000, stat_reg};
        ADDR_IRQ_MASK: rdata_next = {27'h000_0000, mask_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
      stat_reg <= 5'h00;
      mask_reg <= IRQ_MASK_RST;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end
  // control words also return to defaults on a qualified pin reset
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      ctrl0_reg <= CTRL0_RST;
      ctrl18_reg <= CTRL18_RST;
      ctrl19_reg <= CTRL19_RST;
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl18_reg <= ctrl18_next;
      ctrl19_reg <= ctrl19_next;
    end
  end

  assign axi_rsp.awready = !aw_got_reg && !bvalid_reg;
  assign axi_rsp.wready = !w_got_reg && !bvalid_reg;
  assign axi_rsp.bvalid = bvalid_reg;
  assign axi_rsp.bresp = bresp_reg;
  assign axi_rsp.arready = !rvalid_reg;
  assign axi_rsp.rvalid = rvalid_reg;
  assign axi_rsp.rdata = rdata_reg;
  assign axi_rsp.rresp = rresp_reg;

  // ==========================================
  // pointer and divider sync
  logic in_rst_reg, in_rst_next, hand1_reg, hand2_reg, out_rst_reg, out_rst_next;
  logic div_reg, div_next, src_rise;
  always_comb begin
    src_rise = sel_dual ? strobe_rise : frame_rise;
    in_rst_next = frame_rise && en_in;
    out_rst_next = en_out && (sel_dual ? strobe_rise : hand2_reg);
    div_next = en_div && src_rise;
  end
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      in_rst_reg <= 1'b0;
      hand1_reg <= 1'b0;
      hand2_reg <= 1'b0;
      out_rst_reg <= 1'b0;
      div_reg <= 1'b0;
    end else begin
      in_rst_reg <= in_rst_next;
      hand1_reg <= in_rst_reg;
      hand2_reg <= hand1_reg;
      out_rst_reg <= out_rst_next;
      div_reg <= div_next;
    end
  end
  assign in_ptr_reset = in_rst_reg;
  assign out_ptr_reset = out_rst_reg;
  assign divider_sync = div_reg;

  // ==========================================
  // start-up sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (en_in || en_out || en_div) state_next = ST_ARMED;
      ST_ARMED: if (out_rst_reg) state_next = ST_SYNCED;
      ST_SYNCED: if (gate_s[1]) state_next = ST_TX;
      ST_TX: if (!gate_s[1]) state_next = ST_SYNCED;
      default: state_next = ST_IDLE;
    endcase
    if (fault) state_next = ST_IDLE;
  end
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  assign transmit_active = (state_reg == ST_TX);
  assign events = {gate_s[1] && (state_reg == ST_IDLE || state_reg == ST_ARMED),
                   fault, div_reg, out_rst_reg, in_rst_reg};
  assign irq = |(stat_reg & mask_reg);

  // ==========================================
  // checks
  property p_in_ptr;
    @(posedge clk) disable iff (dev_rst) frame_rise && en_in |=> in_ptr_reset;
  endproperty
  a_in_ptr: assert property (p_in_ptr) else $error("input pointer reset missing");
  property p_in_off;
    @(posedge clk) disable iff (dev_rst) in_ptr_reset |-> $past(en_in) && $past(frame_rise);
  endproperty
  a_in_off: assert property (p_in_off) else $error("input pointer reset without cause");
  property p_handoff;
    @(posedge clk) disable iff (dev_rst)
      (in_ptr_reset && !sel_dual && en_out) ##3 (!sel_dual && en_out) |-> out_ptr_reset;
  endproperty
  a_handoff: assert property (p_handoff) else $error("handoff not three cycles");
  property p_dual_out;
    @(posedge clk) disable iff (dev_rst) strobe_rise && sel_dual && en_out |=> out_ptr_reset;
  endproperty
  a_dual_out: assert property (p_dual_out) else $error("strobe did not sync output pointer");
  property p_out_gate;
    @(posedge clk) disable iff (dev_rst) !en_out |=> !out_ptr_reset;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("output pointer synced while disabled");
  property p_div_src;
    @(posedge clk) disable iff (dev_rst)
      divider_sync |-> $past(en_div) && ($past(sel_dual) ? $past(strobe_rise) : $past(frame_rise));
  endproperty
  a_div_src: assert property (p_div_src) else $error("divider sync from wrong source");
  property p_div_on;
    @(posedge clk) disable iff (dev_rst) en_div && src_rise |=> divider_sync;
  endproperty
  a_div_on: assert property (p_div_on) else $error("divider sync dropped");
  property p_tx_start;
    @(posedge clk) disable iff (dev_rst) $rose(transmit_active) |-> $past(state_reg == ST_SYNCED);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit before sync");
  property p_fault;
    @(posedge clk) disable iff (dev_rst) fault |=> !transmit_active ##1 stat_reg[EV_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not handled");
  c_single: cover property (@(posedge clk) disable iff (dev_rst) !sel_dual && out_ptr_reset);
  c_dual: cover property (@(posedge clk) disable iff (dev_rst) sel_dual && divider_sync);
  c_tx: cover property (@(posedge clk) disable iff (dev_rst) $rose(transmit_active));
endmodule // cssu_sync_startup

/* bench/cssu_host_model.sv */
`timescale 1ns/1ns
// ==========================================
// host controller pin model
module cssu_host_model (
  // clock
  input wire logic clk,
  // pins to the device
  output logic transmit_gate_pin,
  output logic active_low_reset_pin,
  output logic frame_sync_pair,
  output logic output_strobe_sync_pair
);
  import cssu_pkg::*;
  initial begin
    transmit_gate_pin = 1'h0;
    active_low_reset_pin = 1'h1;
    frame_sync_pair = 1'h0;
    output_strobe_sync_pair = 1'h0;
  end
  // low pulse, own cycles counted before programming may start
  task automatic reset_pulse();
    active_low_reset_pin <= 1'h0;
    repeat (RESET_MIN_CYC + 3) @(posedge clk);
    active_low_reset_pin <= 1'h1;
    repeat (5) @(posedge clk);
  endtask
  // gate driven to the given level, then held for 8 cycles
  task automatic set_gate(input logic v);
    transmit_gate_pin <= v;
    repeat (8) @(posedge clk);
  endtask
  // one rising edge on the chosen source, then idle low
  task automatic sync_pulse(input logic strobe);
    output_strobe_sync_pair <= strobe;
    frame_sync_pair <= !strobe;
    repeat (2) @(posedge clk);
    frame_sync_pair <= 1'h0;
    output_strobe_sync_pair <= 1'h0;
    repeat (14) @(posedge clk);
  endtask
endmodule // cssu_host_model

/* bench/tb_converter_sync_startup.sv */
`timescale 1ns/1ns
// ==========================================
// bench top
module tb_converter_sync_startup;
  import cssu_pkg::*;
  logic clk;
  logic rstn;
  cssu_axi_req_type req;
  cssu_axi_rsp_type rsp;
  logic gate, prst, frame, strobe, clock_lost_flag, collision_alarm_flag;
  logic in_ptr_reset, out_ptr_reset, divider_sync, transmit_active, irq;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n_in = 0, n_out = 0, n_div = 0, t_in = 0, t_out = 0;
  cssu_sync_startup uut (
    .clk(clk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp),
    .transmit_gate_pin(gate), .active_low_reset_pin(prst), .frame_sync_pair(frame),
    .output_strobe_sync_pair(strobe), .clock_lost_flag(clock_lost_flag),
    .collision_alarm_flag(collision_alarm_flag), .in_ptr_reset(in_ptr_reset),
    .out_ptr_reset(out_ptr_reset), .divider_sync(divider_sync),
    .transmit_active(transmit_active), .irq(irq)
  );
  cssu_host_model host (
    .clk(clk), .transmit_gate_pin(gate), .active_low_reset_pin(prst),
    .frame_sync_pair(frame), .output_strobe_sync_pair(strobe)
  );
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // ==========================================
  // pulse counters with cycle stamps
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (in_ptr_reset === 1'h1) begin
      n_in <= n_in + 1;
      t_in <= cyc;
    end
    if (out_ptr_reset === 1'h1) begin
      n_out <= n_out + 1;
      t_out <= cyc;
    end
    if (divider_sync === 1'h1) n_div <= n_div + 1;
  end
  // ==========================================
  // common tasks
  task automatic give_verdict();
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit done = 0;
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'h1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid === 1'h1) begin
        resp = rsp.bresp;
        req.bready <= 1'h0;
        done = 1;
      end
    end
    // let bready low be seen before the next request
    @(posedge clk);
    if (!done) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit done = 0;
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid === 1'h1) begin
        d = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'h0;
        done = 1;
      end
    end
    // let rready low be seen before the next request
    @(posedge clk);
    if (!done) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic expect_reg(input string name, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(name, d, e);
  endtask
  // ==========================================
  // scenarios
  task automatic t_defaults();
    logic [31:0] d;
    logic [1:0] r;
    expect_reg("ctrl0", ADDR_CTRL0, CTRL0_RST);
    expect_reg("ctrl18", ADDR_CTRL18, CTRL18_RST);
    expect_reg("ctrl19", ADDR_CTRL19, CTRL19_RST);
    expect_reg("status", ADDR_STATUS, 32'h0000_0001);
    axi_read(8'h18, d, r);
    check("unmapped_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("unmapped_rdata", d, 32'h0000_0000);
    axi_write(8'h1C, 32'h0000_FFFF, r);
    check("unmapped_bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_single();
    int a = n_in, b = n_out, c = n_div;
    host.reset_pulse();
    wr(ADDR_CTRL19, 32'h0000_0000);
    wr(ADDR_CTRL0, 32'h0000_0030);
    wr(ADDR_CTRL18, 32'h0000_0002);
    expect_reg("status_armed", ADDR_STATUS, 32'h0000_0002);
    host.sync_pulse(1'h0);
    check("in_ptr", n_in - a, 1);
    check("out_ptr", n_out - b, 1);
    check("div", n_div - c, 1);
    check("handoff", t_out - t_in, 3);
    expect_reg("status_synced", ADDR_STATUS, 32'h0000_0004);
    expect_reg("irq_stat", ADDR_IRQ_STAT, 32'h0000_0007);
    check("irq_masked", irq, 1'h0);
    wr(ADDR_IRQ_MASK, 32'h0000_0007);
    check("irq_on", irq, 1'h1);
    wr(ADDR_IRQ_STAT, 32'h0000_0007);
    check("irq_off", irq, 1'h0);
  endtask
  task automatic t_tx_fault();
    host.set_gate(1'h1);
    check("tx_on", transmit_active, 1'h1);
    expect_reg("status_tx", ADDR_STATUS, 32'h0000_0018);
    host.set_gate(1'h0);
    check("tx_off", transmit_active, 1'h0);
    for (int k = 0; k < 2; k++) begin
      clock_lost_flag <= (k == 0);
      collision_alarm_flag <= (k == 1);
      repeat (5) @(posedge clk);
      clock_lost_flag <= 1'h0;
      collision_alarm_flag <= 1'h0;
      repeat (5) @(posedge clk);
      expect_reg("fault_stat", ADDR_IRQ_STAT, 32'h0000_0008);
      wr(ADDR_IRQ_STAT, 32'h0000_0008);
    end
  endtask
  task automatic t_dual_off();
    int a = n_in, b = n_out, c = n_div;
    wr(ADDR_CTRL19, 32'h0000_0002);
    wr(ADDR_CTRL0, 32'h0000_0030);
    wr(ADDR_CTRL18, 32'h0000_0002);
    host.sync_pulse(1'h0);
    check("dual_frame_out", n_out - b, 0);
    check("dual_frame_div", n_div - c, 0);
    host.sync_pulse(1'h1);
    check("dual_in", n_in - a, 1);
    check("dual_out", n_out - b, 1);
    check("dual_div", n_div - c, 1);
    expect_reg("dual_synced", ADDR_STATUS, 32'h0000_0004);
    wr(ADDR_CTRL0, 32'h0000_0000);
    wr(ADDR_CTRL18, 32'h0000_0000);
    host.sync_pulse(1'h0);
    host.sync_pulse(1'h1);
    check("off_in", n_in - a, 1);
    check("off_out", n_out - b, 1);
    check("off_div", n_div - c, 1);
  endtask
  task automatic t_early();
    wr(ADDR_IRQ_STAT, 32'h0000_001F);
    host.reset_pulse();
    expect_reg("ctrl0_pin_rst", ADDR_CTRL0, CTRL0_RST);
    host.set_gate(1'h1);
    check("early_tx", transmit_active, 1'h0);
    expect_reg("early_stat", ADDR_IRQ_STAT, 32'h0000_0010);
    host.set_gate(1'h0);
    wr(ADDR_IRQ_MASK, 32'h0000_0010);
    check("irq_early", irq, 1'h1);
    // bus reset in mid-run clears status, mask and sequence
    rstn <= 1'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    check("irq_rst", irq, 1'h0);
    expect_reg("stat_rst", ADDR_IRQ_STAT, 32'h0000_0000);
    expect_reg("mask_rst", ADDR_IRQ_MASK, {27'h000_0000, IRQ_MASK_RST});
    expect_reg("status_rst", ADDR_STATUS, 32'h0000_0001);
  endtask
  initial begin
    rstn = 1'h0;
    req = '0;
    clock_lost_flag = 1'h0;
    collision_alarm_flag = 1'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    t_defaults();
    t_single();
    t_tx_fault();
    t_dual_off();
    t_early();
    give_verdict();
  end
endmodule // tb_converter_sync_startup
